// ===== hdl/sfc_flash.sv
`timescale 1ns/1ps
`include "sfc_params.svh"


// Simple flop FIFO carrying program requests to the array.
module sfc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = `SFC_FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage, one word per entry.
  logic [PW-1:0]    wr_q;           // Next slot to fill.
  logic [PW-1:0]    rd_q;           // Oldest slot.
  logic [CW-1:0]    cnt_q;          // Words held.
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != CW'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + PW'(1);
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // Storage is written only; it needs no reset.
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end
endmodule

// Serial command front end: read array and byte program.
module sfc_flash #(
  parameter int BYTE_PROGRAM_TIME_NS = `SFC_BP_TIME_NS
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_sck,
  input  wire logic                    i_si,
  output logic                         o_so,
  output logic                         o_so_oe,
  output logic [`SFC_ADDR_W-1:0]       o_rd_addr,
  input  wire logic [7:0]              i_rd_data,
  input  wire logic [`SFC_SECT_CNT-1:0] i_sect_prot,
  output logic                         o_pgm_valid,
  output sfc_pkg::sfc_pgm_t            o_pgm,
  input  wire logic                    i_pgm_ready,
  output logic                         o_busy,
  output logic                         o_wel
);
  import sfc_pkg::*;

  // Program time rounded up to whole system clocks.
  localparam int BP_CYC = (BYTE_PROGRAM_TIME_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS;

  // Pin synchronisers; stage one is read only by stage two.
  logic [2:0] sck_q;              // Clock pin samples.
  logic [2:0] cs_q;               // Select pin samples.
  logic [1:0] si_q;               // Data pin samples.

  sfc_state_t             st_q;        // Frame phase.
  logic [2:0]             bit_q;       // Bits received in current byte.
  logic [2:0]             obit_q;      // Bits sent in current byte.
  logic [1:0]             nbyte_q;     // Address bytes received.
  logic [7:0]             sh_q;        // Receive shifter.
  logic [7:0]             op_q;        // Opcode of this frame.
  logic [7:0]             out_q;       // Transmit shifter.
  logic [`SFC_ADDR_W-1:0] addr_q;      // Address counter.
  logic [7:0]             pdata_q;     // Latched program byte.
  logic                   pgot_q;      // A full program byte arrived.
  logic                   stat_src_q;  // Stream status instead of array.
  logic                   wel_q;       // Write enable latch.
  logic                   seq_q;       // Sequential program mode.
  logic [`SFC_ADDR_W-1:0] seq_addr_q;  // Next sequential target.
  logic                   busy_q;      // Program cycle in progress.
  logic [15:0]            tmr_q;       // Cycles left in program cycle.
  sfc_pgm_t               pgm_q;       // Request being programmed.
  logic                   so_q;
  logic                   so_oe_q;

  // Edge detection on the synchronised pins.
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic [7:0] rx_byte;
  logic       byte_done;
  assign sck_rise  = sck_q[1] && !sck_q[2];
  assign sck_fall  = !sck_q[1] && sck_q[2];
  assign cs_fall   = !cs_q[1] && cs_q[2];
  assign cs_rise   = cs_q[1] && !cs_q[2];
  assign cs_low    = !cs_q[2];
  assign rx_byte   = {sh_q[6:0], si_q[1]};
  assign byte_done = sck_rise && (bit_q == 3'h7);

  // Opcode decoding from the byte that just completed.
  logic is_read;
  logic is_fast;
  logic is_byte_pgm;
  logic is_seq_pgm;
  logic is_other;
  assign is_fast     = (rx_byte == `SFC_OP_READ_FAST);
  assign is_read     = is_fast || (rx_byte == `SFC_OP_READ_SLOW);
  assign is_byte_pgm = (rx_byte == `SFC_OP_BYTE_PGM);
  assign is_seq_pgm  = (rx_byte == `SFC_OP_SEQ_PGM);
  // Opcodes owned by other blocks are accepted here and take no action.
  assign is_other    = (rx_byte == `SFC_OP_ERASE_4K) || (rx_byte == `SFC_OP_ERASE_32K)
                    || (rx_byte == `SFC_OP_ERASE_64K) || (rx_byte == `SFC_OP_CHIP_ERA_A)
                    || (rx_byte == `SFC_OP_CHIP_ERA_B)
                    || (rx_byte == `SFC_OP_PROT_SECT) || (rx_byte == `SFC_OP_UNPROT_SECT)
                    || (rx_byte == `SFC_OP_RD_PROT) || (rx_byte == `SFC_OP_WR_STATUS)
                    || (rx_byte == `SFC_OP_RD_ID) || (rx_byte == `SFC_OP_PWR_DOWN)
                    || (rx_byte == `SFC_OP_PWR_RESUME);

  // Map an address to its protection sector.
  function automatic logic sect_locked(input logic [`SFC_ADDR_W-1:0] a,
                                       input logic [`SFC_SECT_CNT-1:0] p);
    logic [3:0] idx;
    if (a < `SFC_SECT_SMALL) begin
      idx = {1'b0, a[18:16]};
    end else if (a < `SFC_SECT_8K_A) begin
      idx = 4'h7;
    end else if (a < `SFC_SECT_8K_B) begin
      idx = 4'h8;
    end else if (a < `SFC_SECT_TOP) begin
      idx = 4'h9;
    end else begin
      idx = 4'hA;
    end
    return p[idx];
  endfunction

  // Status byte and the byte that the next output phase sends.
  logic [7:0] status_byte;
  logic [7:0] tx_src;
  assign status_byte = (8'(busy_q) << `SFC_ST_BUSY_BIT) | (8'(wel_q) << `SFC_ST_WEL_BIT);
  assign tx_src      = stat_src_q ? status_byte : i_rd_data;

  // Program bookkeeping on release of select.
  logic pgm_frame;
  logic pgm_ok;
  logic pgm_push;
  logic fifo_ready;
  logic [`SFC_ADDR_W-1:0] next_seq;
  logic seq_end;
  assign pgm_frame = ((op_q == `SFC_OP_BYTE_PGM) || (op_q == `SFC_OP_SEQ_PGM))
                  && ((st_q == SFC_ADDR) || (st_q == SFC_PDATA));
  assign pgm_ok    = (st_q == SFC_PDATA) && pgot_q && !busy_q
                  && !sect_locked(addr_q, i_sect_prot);
  assign pgm_push  = busy_q && (tmr_q == 16'h0000);
  assign next_seq  = pgm_q.addr + `SFC_ADDR_ONE;
  // Sequential mode neither wraps nor skips a protected sector.
  assign seq_end   = (pgm_q.addr == `SFC_ADDR_MAX) || sect_locked(next_seq, i_sect_prot);

  // Pin synchronisers.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sck_q <= 3'h0;
      cs_q  <= 3'h7;
      si_q  <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], i_sck};
      cs_q  <= {cs_q[1:0], i_cs_n};
      si_q  <= {si_q[0], i_si};
    end
  end

  // Frame sequencer: all serial fields are taken on rising clock edges.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q       <= SFC_IDLE;
      bit_q      <= 3'h0;
      nbyte_q    <= 2'h0;
      sh_q       <= 8'h00;
      op_q       <= 8'h00;
      addr_q     <= `SFC_ADDR_ZERO;
      pdata_q    <= 8'h00;
      pgot_q     <= 1'b0;
      stat_src_q <= 1'b0;
    end else if (cs_fall) begin
      st_q    <= SFC_OPCODE;
      bit_q   <= 3'h0;
      nbyte_q <= 2'h0;
      pgot_q  <= 1'b0;
    end else if (!cs_low) begin
      st_q <= SFC_IDLE;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= rx_byte;
      if (byte_done) begin
        unique case (st_q)
          SFC_OPCODE: begin
            op_q       <= rx_byte;
            stat_src_q <= 1'b0;
            if (busy_q && rx_byte != `SFC_OP_RD_STATUS) begin
              // Only status polling is served during a program cycle.
              st_q <= SFC_IGNORE;
            end else if (rx_byte == `SFC_OP_RD_STATUS) begin
              stat_src_q <= 1'b1;
              st_q       <= SFC_RDATA;
            end else if (is_read) begin
              st_q <= SFC_ADDR;
            end else if (is_byte_pgm) begin
              st_q <= wel_q ? SFC_ADDR : SFC_IGNORE;
            end else if (is_seq_pgm && seq_q) begin
              addr_q <= seq_addr_q;
              st_q   <= SFC_PDATA;
            end else if (is_seq_pgm) begin
              st_q <= wel_q ? SFC_ADDR : SFC_IGNORE;
            end else if (is_other || rx_byte == `SFC_OP_WR_EN || rx_byte == `SFC_OP_WR_DIS) begin
              st_q <= SFC_DONE;
            end else begin
              st_q <= SFC_IGNORE;
            end
          end
          SFC_ADDR: begin
            // Shifting into 19 bits drops the five unused top bits.
            addr_q  <= {addr_q[10:0], rx_byte};
            nbyte_q <= nbyte_q + 2'h1;
            if (nbyte_q == `SFC_ADDR_BYTES) begin
              if (op_q == `SFC_OP_READ_FAST) begin
                st_q <= SFC_DUMMY;
              end else if (op_q == `SFC_OP_READ_SLOW) begin
                st_q <= SFC_RDATA;
              end else begin
                st_q <= SFC_PDATA;
              end
            end
          end
          SFC_DUMMY: begin
            st_q <= SFC_RDATA;
          end
          SFC_PDATA: begin
            if (!pgot_q) begin
              pdata_q <= rx_byte;
              pgot_q  <= 1'b1;
            end
          end
          default: begin
            st_q <= st_q;  // Read, done and ignore phases take no input.
          end
        endcase
      end
    end else if (sck_fall && st_q == SFC_RDATA && obit_q == 3'h7 && !stat_src_q) begin
      // Counter advances as each array byte is loaded; wrap is free.
      addr_q <= addr_q + `SFC_ADDR_ONE;
    end
  end

  // Output shifter: a new bit leaves on each falling edge of a read phase.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      out_q   <= 8'h00;
      obit_q  <= 3'h7;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (!cs_low || st_q != SFC_RDATA) begin
      obit_q  <= 3'h7;
      so_oe_q <= 1'b0;
    end else if (sck_fall) begin
      obit_q  <= obit_q + 3'h1;
      so_oe_q <= 1'b1;
      if (obit_q == 3'h7) begin
        so_q  <= tx_src[7];
        out_q <= {tx_src[6:0], 1'b0};
      end else begin
        so_q  <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // Latch, sequential mode and the self-timed program cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wel_q      <= 1'b0;
      seq_q      <= 1'b0;
      seq_addr_q <= `SFC_ADDR_ZERO;
      busy_q     <= 1'b0;
      tmr_q      <= 16'h0000;
      pgm_q      <= '0;
    end else begin
      if (busy_q && tmr_q != 16'h0000) begin
        tmr_q <= tmr_q - 16'h0001;
      end else if (pgm_push && fifo_ready) begin
        // Busy holds until the request FIFO has room for the request.
        busy_q <= 1'b0;
        if (seq_q && seq_end) begin
          seq_q <= 1'b0;
          wel_q <= 1'b0;
        end else if (seq_q) begin
          seq_addr_q <= next_seq;
        end
      end
      if (byte_done && st_q == SFC_OPCODE && !busy_q) begin
        if (rx_byte == `SFC_OP_WR_EN) begin
          wel_q <= 1'b1;
        end else if (rx_byte == `SFC_OP_WR_DIS) begin
          wel_q <= 1'b0;
          seq_q <= 1'b0;
        end
      end
      if (cs_rise && pgm_frame) begin
        if (pgm_ok) begin
          busy_q <= 1'b1;
          tmr_q  <= 16'(BP_CYC);
          pgm_q  <= '{addr: addr_q, data: pdata_q};
          if (op_q == `SFC_OP_SEQ_PGM) begin
            seq_q <= 1'b1;
          end else begin
            wel_q <= 1'b0;
          end
        end else begin
          wel_q <= 1'b0;
          seq_q <= 1'b0;
        end
      end
    end
  end

  sfc_fifo #(
    .WIDTH ($bits(sfc_pgm_t)),
    .DEPTH (`SFC_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (pgm_push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (pgm_q),
    .o_out_valid (o_pgm_valid),
    .i_out_ready (i_pgm_ready),
    .o_out_data  (o_pgm)
  );

  assign o_so      = so_q;
  assign o_so_oe   = so_oe_q;
  assign o_rd_addr = addr_q;
  assign o_busy    = busy_q;
  assign o_wel     = wel_q;
endmodule

// ===== pkg/sfc_params.svh
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// Opcodes handled by the command front end.
`define SFC_OP_READ_FAST   8'h0B
`define SFC_OP_READ_SLOW   8'h03
`define SFC_OP_ERASE_4K    8'h20
`define SFC_OP_ERASE_32K   8'h52
`define SFC_OP_ERASE_64K   8'hD8
`define SFC_OP_CHIP_ERA_A  8'h60
`define SFC_OP_CHIP_ERA_B  8'hC7
`define SFC_OP_BYTE_PGM    8'h02
`define SFC_OP_SEQ_PGM     8'hAF
`define SFC_OP_WR_EN       8'h06
`define SFC_OP_WR_DIS      8'h04
`define SFC_OP_PROT_SECT   8'h36
`define SFC_OP_UNPROT_SECT 8'h39
`define SFC_OP_RD_PROT     8'h3C
`define SFC_OP_RD_STATUS   8'h05
`define SFC_OP_WR_STATUS   8'h01
`define SFC_OP_RD_ID       8'h9F
`define SFC_OP_PWR_DOWN    8'hB9
`define SFC_OP_PWR_RESUME  8'hAB

// Array geometry: 19 address bits, last byte at the top.
`define SFC_ADDR_W         19
`define SFC_ADDR_MAX       19'h7FFFF
`define SFC_ADDR_ZERO      19'h00000
`define SFC_ADDR_ONE       19'h00001
`define SFC_ADDR_BYTES     2'h2
`define SFC_SECT_SMALL     19'h70000
`define SFC_SECT_8K_A      19'h78000
`define SFC_SECT_8K_B      19'h7A000
`define SFC_SECT_TOP       19'h7C000
`define SFC_SECT_CNT       11

// Status byte layout and timing.
`define SFC_ST_BUSY_BIT    0
`define SFC_ST_WEL_BIT     1
`define SFC_CLK_PERIOD_NS  40
`define SFC_BP_TIME_NS     20000
`define SFC_FIFO_DEPTH     32

`endif

// ===== pkg/sfc_pkg.sv
`include "sfc_params.svh"

package sfc_pkg;

  // One program request handed to the array: target address and byte.
  typedef struct packed {
    logic [`SFC_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } sfc_pgm_t;

  // Phases of one chip-select frame.
  typedef enum logic [2:0] {
    SFC_IDLE,
    SFC_OPCODE,
    SFC_ADDR,
    SFC_DUMMY,
    SFC_RDATA,
    SFC_PDATA,
    SFC_DONE,
    SFC_IGNORE
  } sfc_state_t;

endpackage

// ===== bench/sfc_flash_asserts.sv
`timescale 1ns/1ps
`include "sfc_params.svh"

// Pin-level checker for the command front end; it only watches.
module sfc_flash_asserts #(
  parameter int BYTE_PROGRAM_TIME_NS = 20000
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              i_cs_n,
  input wire logic              i_sck,
  input wire logic              o_so,
  input wire logic              o_so_oe,
  input wire logic              o_pgm_valid,
  input wire sfc_pkg::sfc_pgm_t o_pgm,
  input wire logic              i_pgm_ready,
  input wire logic              o_busy,
  input wire logic              o_wel
);
  import sfc_pkg::*;

  localparam int BP_CYC = BYTE_PROGRAM_TIME_NS / `SFC_CLK_PERIOD_NS;  // Program cycle length.

  logic [15:0] busy_cnt_q;  // Cycles spent busy so far.

  // Counts busy cycles; the cycle must not end early.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !o_busy)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= busy_cnt_q + 16'h0001;
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_oe_idle_off: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("serial output driven while deselected");
  a_oe_needs_sel: assert property ($rose(o_so_oe) |-> !i_cs_n)
    else $error("serial output enabled outside a frame");
  a_so_on_fall: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck))
    else $error("serial output moved while clock high");
  a_wel_in_frame: assert property ($rose(o_wel) |-> !$past(i_cs_n, 3))
    else $error("write enable latch set outside a frame");
  a_busy_needs_wel: assert property ($rose(o_busy) |-> $past(o_wel))
    else $error("program started without write enable");
  a_busy_at_release: assert property ($rose(o_busy) |-> i_cs_n)
    else $error("program started before release");
  a_busy_min_len: assert property ($fell(o_busy) |-> busy_cnt_q >= BP_CYC - 1)
    else $error("program cycle too short");
  a_push_at_end: assert property ($fell(o_busy) |-> ##[0:2] o_pgm_valid)
    else $error("no program request after busy");
  a_valid_after_busy: assert property ($rose(o_pgm_valid) |-> $past(o_busy))
    else $error("program request without program cycle");
  a_head_holds: assert property (o_pgm_valid && !i_pgm_ready |=> o_pgm_valid && $stable(o_pgm))
    else $error("stalled program request changed");

  c_program: cover property ($rose(o_busy));
  c_read: cover property ($rose(o_so_oe));
  c_stall: cover property (o_pgm_valid && !i_pgm_ready);
endmodule

bind sfc_flash sfc_flash_asserts #(.BYTE_PROGRAM_TIME_NS(BYTE_PROGRAM_TIME_NS)) i_sfc_flash_asserts (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_pgm_valid(o_pgm_valid), .o_pgm(o_pgm), .i_pgm_ready(i_pgm_ready),
  .o_busy(o_busy), .o_wel(o_wel));

// ===== bench/sfc_spi_host.sv
`timescale 1ns/1ps

// Mode 0 host on the link; all pins change just after a falling system edge.
module sfc_spi_host (
  input  wire logic i_sys_clk,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  input  wire logic i_so
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end

  // Half a link period: 4 system clocks, so 320 ns per period.
  task automatic half();
    repeat (4) @(negedge i_sys_clk);
  endtask

  // Selects the device and leaves a gap before the first clock edge.
  task automatic sel();
    @(negedge i_sys_clk);
    o_cs_n <= 1'b0;
    half();
  endtask

  // Shifts n bits, most significant first; output is sampled late in the high phase,
  // because the device answers several system clocks after each fall.
  task automatic bits(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'hFF;
    for (int i = 0; i < n; i++) begin
      o_sck <= 1'b0;
      o_si  <= tx[7-i];
      half();
      o_sck <= 1'b1;
      half();
      rx[7-i] = i_so;
    end
  endtask

  // Releases select; the data line flips so a stale bit is never mistaken for a live one.
  task automatic desel();
    o_sck <= 1'b0;
    half();
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    repeat (8) @(negedge i_sys_clk);
  endtask
endmodule

// ===== bench/sfc_flash_tb_top.sv
`timescale 1ns/1ps
`include "sfc_params.svh"

// Bench: host model on the link, a pattern array on the read port.
module sfc_flash_tb_top;
  import sfc_pkg::*;

  localparam int BP_NS = 8000;  // Long enough for a status read to see busy.

  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           cs_n, sck, si, so, so_oe, pgm_valid, busy, write_enable_latch;
  logic           pgm_ready = 1'b1;
  logic [10:0]    sect_prot = 11'h000;
  logic [18:0]    rd_addr;
  sfc_pgm_t       pgm;
  logic [7:0]     rx;
  int             mismatches = 0;
  int             n_compared = 0;
  int             cyc = 0;

  // Array contents are a fixed pattern of the address; the top byte and byte zero differ.
  function automatic logic [7:0] arr(input logic [18:0] a);
    return a[7:0] + a[18:11];
  endfunction

  always #20 clk = ~clk;

  sfc_flash #(.BYTE_PROGRAM_TIME_NS(BP_NS)) i_sfc_flash (
    .i_sys_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .o_rd_addr(rd_addr), .i_rd_data(arr(rd_addr)), .i_sect_prot(sect_prot),
    .o_pgm_valid(pgm_valid), .o_pgm(pgm), .i_pgm_ready(pgm_ready), .o_busy(busy), .o_wel(write_enable_latch));

  // An undriven output shows the inverse of its last bit, so a stale bit never passes.
  sfc_spi_host i_sfc_spi_host (
    .i_sys_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_oe ? so : ~so));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic sel();
    i_sfc_spi_host.sel();
  endtask
  task automatic desel();
    i_sfc_spi_host.desel();
  endtask
  task automatic xb(input logic [7:0] tx);
    i_sfc_spi_host.bits(8, tx, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    sel();
    xb(op);
    desel();
  endtask
  // Waits for the request that ends a program cycle; it stands one cycle when ready is high.
  task automatic wait_pgm();
    for (int n = 0; n < 400 && pgm_valid !== 1'b1; n++)
      @(negedge clk);
  endtask

  // Slow read near the top with junk in the high address bits, then a mid-byte release.
  task automatic t_read();
    logic [18:0] a;
    sel();
    xb(8'h03);
    xb(8'hF7);
    xb(8'hFF);
    xb(8'hFE);
    for (int i = 0; i < 3; i++) begin
      a = 19'h7FFFE + i[18:0];
      xb(8'h00);
      chk(rx, arr(a), "read data");
    end
    chk(so_oe, 1'b1, "output off in data phase");
    i_sfc_spi_host.bits(3, 8'h00, rx);
    desel();
    chk(so_oe, 1'b0, "output on after release");
    $display("read test done");
  endtask

  // Fast read: the output must stay off through the dummy byte.
  task automatic t_fast();
    sel();
    xb(8'h0B);
    xb(8'h00);
    xb(8'h00);
    xb(8'h10);
    xb(8'hA5);
    chk(so_oe, 1'b0, "output on before data");
    xb(8'h00);
    chk(rx, arr(19'h00010), "fast read first byte");
    xb(8'h00);
    chk(rx, arr(19'h00011), "fast read second byte");
    desel();
    $display("fast read test done");
  endtask

  // Program with a stalled array port, status polled while busy.
  task automatic t_prog();
    @(negedge clk) pgm_ready <= 1'b0;
    cmd(8'h06);
    chk(write_enable_latch, 1'b1, "latch not set");
    sel();
    xb(8'h02);
    xb(8'h00);
    xb(8'h12);
    xb(8'h34);
    xb(8'hA5);
    xb(8'h5A);
    desel();
    chk(busy, 1'b1, "no program cycle");
    chk(write_enable_latch, 1'b0, "latch kept");
    sel();
    xb(8'h05);
    xb(8'h00);
    desel();
    chk(rx, 8'h01, "status not busy");
    for (int n = 0; n < 400 && pgm_valid !== 1'b1; n++)
      @(negedge clk);
    chk(pgm, {19'h01234, 8'hA5}, "program request");
    repeat (20) @(negedge clk);
    chk(pgm_valid, 1'b1, "request lost in stall");
    pgm_ready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      sel();
      xb(8'h05);
      xb(8'h00);
      desel();
      if (rx[0] === 1'b0)
        break;
    end
    chk(rx[0], 1'b0, "busy never ended");
    $display("program test done");
  endtask

  // Sequential program: address only once, next byte goes to the next address, no wrap.
  task automatic t_seq();
    cmd(8'h06);
    sel();
    xb(8'hAF);
    xb(8'h00);
    xb(8'h20);
    xb(8'h00);
    xb(8'h11);
    desel();
    wait_pgm();
    chk(pgm, {19'h02000, 8'h11}, "first sequential byte");
    chk(write_enable_latch, 1'b1, "latch lost in sequential mode");
    sel();
    xb(8'hAF);
    xb(8'h22);
    desel();
    wait_pgm();
    chk(pgm, {19'h02001, 8'h22}, "next sequential address");
    cmd(8'h04);
    chk(write_enable_latch, 1'b0, "disable left sequential latch");
    cmd(8'h06);
    sel();
    xb(8'hAF);
    xb(8'h07);
    xb(8'hFF);
    xb(8'hFF);
    xb(8'h33);
    desel();
    wait_pgm();
    chk(pgm, {19'h7FFFF, 8'h33}, "top sequential byte");
    chk(write_enable_latch, 1'b0, "sequential mode kept at array end");
    sel();
    xb(8'hAF);
    xb(8'h44);
    desel();
    chk(busy, 1'b0, "sequential program wrapped");
    $display("sequential test done");
  endtask

  // No latch, short address, short data, locked sector: none may program.
  task automatic t_refuse();
    logic [7:0] pay [4];
    int         nb [4];
    pay = '{8'h00, 8'h01, 8'h00, 8'h77};
    nb = '{32, 16, 28, 32};
    for (int k = 0; k < 4; k++) begin
      @(negedge clk) sect_prot <= (k == 3) ? 11'h001 : 11'h000;
      if (k > 0)
        cmd(8'h06);
      sel();
      xb(8'h02);
      for (int j = 0; j < nb[k]; j += 8)
        i_sfc_spi_host.bits((nb[k] - j >= 8) ? 8 : nb[k] - j, pay[j/8], rx);
      desel();
      chk(busy, 1'b0, "refused program ran");
      chk(write_enable_latch, 1'b0, "latch kept on abort");
      chk(pgm_valid, 1'b0, "refused program queued");
    end
    sect_prot <= 11'h000;
    $display("refusal test done");
  endtask

  // Unknown opcode, short opcode, then every other listed opcode.
  task automatic t_opcodes();
    logic [7:0] ops [14];
    ops = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h36, 8'h39, 8'h3C, 8'h05, 8'h01, 8'h9F,
            8'hB9, 8'hAB, 8'h04};
    sel();
    xb(8'hFF);
    xb(8'h06);
    desel();
    chk(write_enable_latch, 1'b0, "input taken after bad opcode");
    sel();
    i_sfc_spi_host.bits(4, 8'h00, rx);
    desel();
    cmd(8'h06);
    chk(write_enable_latch, 1'b1, "not idle after short opcode");
    foreach (ops[i]) begin
      sel();
      xb(ops[i]);
      xb(8'h00);
      xb(8'h00);
      xb(8'h00);
      desel();
      chk(busy | pgm_valid, 1'b0, "opcode started a program");
    end
    chk(write_enable_latch, 1'b0, "disable left latch set");
    $display("opcode test done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang is cut short well above the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    t_read();
    t_fast();
    t_prog();
    t_seq();
    t_refuse();
    t_opcodes();
    wrap_up();
  end
endmodule
